// ---- rtl/can_xcvr_ctrl.sv ----
`timescale 1ns/1ns
// Behaviour
// - Normal mode drives dominant while transmit input low, else bus released.
// - Normal or silent: receive output low when bus dominant, high otherwise.
// - Silent mode disables transmitter; receiver and others run as normal.
// - Five modes chosen from enable, standby select and wake events.
// - Standby: transmitter and receiver off, receive output shows pending wake.
// - Regulator switch active in normal, silent, standby and go-to-sleep modes.
// - Go-to-sleep reachable from any mode but sleep; after sleep-entry delay enter sleep.
// - Never enter sleep while the wake flag is set.
// - Sleep: all off, regulator floats, wake watched, pins still change mode.
// - Seven diagnostic flags; five shown on error output per mode.
// - Core supply low flag: set on undervoltage, clears on listed events; code also clears it as soon as undervoltage ends.
// - Battery low flag set on battery undervoltage, clears on recovery only.
// - Power-on flag set at battery power-up, shown silent, cleared entering normal.
// - Wake flag set on wake request; shown in low-power modes; cleared listed.
// - Wake-source flag set on local wake; shown in normal; cleared leaving.
// - Bus failure after four failing transmit cycles; shown in normal.
// - Local failure on four events; shown silent; cleared on listed events.
// - Sleep-entry delay lies between 20 and 50 microseconds.
// - Remote wake needs dominant, recessive, dominant phases within time-out.
// - Transmit low beyond dominant time-out disables transmitter until cleared.
module can_xcvr_ctrl #(
   parameter int SLEEP_CYC = can_xcvr_pkg::SLEEP_DELAY_CYC,
   parameter int WAKE_TO   = can_xcvr_pkg::WAKE_TO_CYC,
   parameter int TX_DTO    = can_xcvr_pkg::TX_DTO_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Microcontroller pins
   input  wire logic tx_data,
   input  wire logic enable,
   input  wire logic standby_select_low,
   output logic      rx_data,
   output logic      error_low,
   // Bus side
   input  wire logic bus_dominant,
   output logic      bus_drive,
   output logic      regulator_switch_out,
   output logic      regulator_switch_oe,
   // Analog monitors
   input  wire logic core_supply_uv,
   input  wire logic battery_uv,
   input  wire logic battery_power_up,
   input  wire logic local_wake,
   input  wire logic bus_short,
   input  wire logic tx_rx_short,
   input  wire logic bus_clamp,
   input  wire logic over_temp,
   // Mode observation
   output can_xcvr_pkg::mode_t mode
);

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   localparam int NSYNC = 13;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   logic [NSYNC-1:0] raw_in;

   assign raw_in = {tx_data, enable, standby_select_low, bus_dominant, core_supply_uv,
                    battery_uv, battery_power_up, local_wake, bus_short, tx_rx_short,
                    bus_clamp, over_temp, 1'b0};

   // Two stages ahead of any logic; reset to transmit recessive and standby pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 13'h1000;
         sync_b <= 13'h1000;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   logic s_tx, s_en, s_stb, s_dom, s_cuv, s_buv, s_pup, s_lwk, s_bsh, s_trs, s_bcl, s_ot;
   assign {s_tx, s_en, s_stb, s_dom, s_cuv, s_buv, s_pup, s_lwk, s_bsh, s_trs, s_bcl, s_ot}
      = sync_b[NSYNC-1:1];

   // -----------------------------------------------------------------
   // Flags
   // -----------------------------------------------------------------
   logic core_supply_low_flag;
   logic battery_low_flag;
   logic power_on_flag;
   logic wake_flag;
   logic wake_source_flag;
   logic bus_fail_flag;
   logic local_fail_flag;
   logic tx_timeout_flag;
   logic stb_prev;
   logic remote_wake;
   can_xcvr_pkg::mode_t next_mode;

   logic enter_normal;
   logic leave_normal;
   logic stb_rise;
   logic wake_set;
   logic pwon_set;
   logic cuv_set;

   assign enter_normal = (next_mode == can_xcvr_pkg::MODE_NORMAL) &&
                         (mode != can_xcvr_pkg::MODE_NORMAL);
   assign leave_normal = (next_mode != can_xcvr_pkg::MODE_NORMAL) &&
                         (mode == can_xcvr_pkg::MODE_NORMAL);
   assign stb_rise     = s_stb && !stb_prev;
   assign pwon_set     = s_pup && !power_on_flag;
   assign cuv_set      = s_cuv && !core_supply_low_flag;
   assign wake_set     = (s_lwk || remote_wake) && (mode != can_xcvr_pkg::MODE_NORMAL);

   // Edge memory of standby select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) stb_prev <= 1'b1;
      else        stb_prev <= s_stb;
   end

   // Core supply undervoltage flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_supply_low_flag <= 1'b0;
      end else if (s_cuv) begin
         core_supply_low_flag <= 1'b1;
      end else if (pwon_set || wake_set || stb_rise || !s_cuv) begin
         core_supply_low_flag <= 1'b0;
      end
   end

   // Battery undervoltage flag follows the monitor
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) battery_low_flag <= 1'b0;
      else        battery_low_flag <= s_buv;
   end

   // Battery power-on flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)            power_on_flag <= 1'b0;
      else if (s_pup)        power_on_flag <= 1'b1;
      else if (enter_normal) power_on_flag <= 1'b0;
   end

   // Wake flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)                        wake_flag <= 1'b0;
      else if (wake_set)                 wake_flag <= 1'b1;
      else if (enter_normal || cuv_set)  wake_flag <= 1'b0;
   end

   // Wake-source flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)                 wake_source_flag <= 1'b0;
      else if (wake_set && s_lwk) wake_source_flag <= 1'b1;
      else if (leave_normal)      wake_source_flag <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Bus failure: count failing dominant-recessive transmit cycles
   // -----------------------------------------------------------------
   logic [2:0] fail_count;
   logic       tx_prev;
   logic       fail_in_cycle;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fail_count    <= 3'h0;
         tx_prev       <= 1'b1;
         fail_in_cycle <= 1'b0;
      end else begin
         tx_prev <= s_tx;
         if (!s_tx && bus_drive && s_bsh) fail_in_cycle <= 1'b1;
         if (s_tx && !tx_prev) begin
            fail_in_cycle <= 1'b0;
            if (fail_in_cycle) fail_count <= fail_count + 3'h1;
            else               fail_count <= 3'h0;
         end
         if (mode != can_xcvr_pkg::MODE_NORMAL) fail_count <= 3'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         bus_fail_flag <= 1'b0;
      else if (fail_count == 3'(can_xcvr_pkg::BUS_FAIL_CYCLES))
         bus_fail_flag <= 1'b1;
      else if (enter_normal || pwon_set)
         bus_fail_flag <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Transmit dominant time-out
   // -----------------------------------------------------------------
   logic [can_xcvr_pkg::CNT_W-1:0] dto_count;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)                        dto_count <= '0;
      else if (s_tx)                     dto_count <= '0;
      else if (dto_count != TX_DTO[can_xcvr_pkg::CNT_W-1:0])
         dto_count <= dto_count + 1'b1;
   end

   assign tx_timeout_flag = (dto_count == TX_DTO[can_xcvr_pkg::CNT_W-1:0]);

   // Local failure flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         local_fail_flag <= 1'b0;
      else if (tx_timeout_flag || s_trs || s_bcl || s_ot)
         local_fail_flag <= 1'b1;
      else if (enter_normal || (s_dom && s_tx) || pwon_set)
         local_fail_flag <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Remote wake detector: dominant, recessive, dominant
   // -----------------------------------------------------------------
   logic [1:0]                     wk_phase;
   logic [can_xcvr_pkg::CNT_W-1:0] wk_filter;
   logic [can_xcvr_pkg::CNT_W-1:0] wk_timer;
   logic                           wk_level;

   assign wk_level = (wk_phase == 2'h1) ? !s_dom : s_dom;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wk_phase    <= 2'h0;
         wk_filter   <= '0;
         wk_timer    <= '0;
         remote_wake <= 1'b0;
      end else begin
         remote_wake <= 1'b0;
         if (mode == can_xcvr_pkg::MODE_NORMAL || mode == can_xcvr_pkg::MODE_SILENT) begin
            wk_phase  <= 2'h0;
            wk_filter <= '0;
            wk_timer  <= '0;
         end else if (wk_phase != 2'h0 && wk_timer == WAKE_TO[can_xcvr_pkg::CNT_W-1:0]) begin
            wk_phase  <= 2'h0;
            wk_filter <= '0;
            wk_timer  <= '0;
         end else begin
            if (wk_phase != 2'h0 || s_dom) wk_timer <= wk_timer + 1'b1;
            else                           wk_timer <= '0; // Restart on idle bus
            if (!wk_level) begin
               wk_filter <= '0;
            end else if (wk_filter ==
                         can_xcvr_pkg::WAKE_FILTER_CYC[can_xcvr_pkg::CNT_W-1:0]) begin
               wk_filter <= '0;
               if (wk_phase == 2'h2) begin
                  remote_wake <= 1'b1;
                  wk_phase    <= 2'h0;
                  wk_timer    <= '0;
               end else begin
                  wk_phase <= wk_phase + 2'h1;
               end
            end else begin
               wk_filter <= wk_filter + 1'b1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Mode selection
   // -----------------------------------------------------------------
   logic [can_xcvr_pkg::CNT_W-1:0] sleep_count;
   logic                           sleep_due;

   assign sleep_due = (sleep_count == SLEEP_CYC[can_xcvr_pkg::CNT_W-1:0]);

   always_comb begin
      unique case ({s_en, s_stb})
         can_xcvr_pkg::SEL_NORMAL:  next_mode = can_xcvr_pkg::MODE_NORMAL;
         can_xcvr_pkg::SEL_SILENT:  next_mode = can_xcvr_pkg::MODE_SILENT;
         can_xcvr_pkg::SEL_STANDBY: next_mode = can_xcvr_pkg::MODE_STANDBY;
         default: begin
            // Sleep held until pins change; sleep once delay is due and no wake flag; go-to-sleep otherwise
            if (mode == can_xcvr_pkg::MODE_SLEEP)
               next_mode = can_xcvr_pkg::MODE_SLEEP;
            else if (mode == can_xcvr_pkg::MODE_GO_SLEEP && sleep_due && !wake_flag)
               next_mode = can_xcvr_pkg::MODE_SLEEP;
            else
               next_mode = can_xcvr_pkg::MODE_GO_SLEEP;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) mode <= can_xcvr_pkg::MODE_STANDBY;
      else        mode <= next_mode;
   end

   // Dwell timer in go-to-sleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         sleep_count <= '0;
      else if (mode != can_xcvr_pkg::MODE_GO_SLEEP)
         sleep_count <= '0;
      else if (!sleep_due)
         sleep_count <= sleep_count + 1'b1;
   end

   // -----------------------------------------------------------------
   // Output stage
   // -----------------------------------------------------------------
   logic next_err;

   always_comb begin
      unique case (mode)
         can_xcvr_pkg::MODE_NORMAL:
            next_err = wake_source_flag || bus_fail_flag;
         can_xcvr_pkg::MODE_SILENT:
            next_err = power_on_flag || local_fail_flag;
         can_xcvr_pkg::MODE_STANDBY,
         can_xcvr_pkg::MODE_GO_SLEEP,
         can_xcvr_pkg::MODE_SLEEP:
            next_err = wake_flag;
         default:
            next_err = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_drive            <= 1'b0;
         rx_data              <= 1'b1;
         error_low            <= 1'b1;
         regulator_switch_out <= 1'b1;
         regulator_switch_oe  <= 1'b1;
      end else begin
         bus_drive <= (mode == can_xcvr_pkg::MODE_NORMAL) && !s_tx &&
                      !tx_timeout_flag && !local_fail_flag;
         if (mode == can_xcvr_pkg::MODE_NORMAL || mode == can_xcvr_pkg::MODE_SILENT)
            rx_data <= !s_dom;
         else if (mode == can_xcvr_pkg::MODE_STANDBY)
            rx_data <= !wake_flag;
         else
            rx_data <= 1'b1;
         error_low            <= !next_err;
         regulator_switch_out <= 1'b1;
         regulator_switch_oe  <= (mode != can_xcvr_pkg::MODE_SLEEP);
      end
   end

endmodule

// ---- rtl/can_xcvr_pkg.sv ----
package can_xcvr_pkg;

   // -----------------------------------------------------------------
   // Operating modes
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_SILENT,
      MODE_STANDBY,
      MODE_GO_SLEEP,
      MODE_SLEEP
   } mode_t;

   // -----------------------------------------------------------------
   // Pin level encoding of each mode, as {enable, standby_select_low}
   // -----------------------------------------------------------------
   localparam logic [1:0] SEL_NORMAL   = 2'h3;
   localparam logic [1:0] SEL_SILENT   = 2'h1;
   localparam logic [1:0] SEL_STANDBY  = 2'h0;
   localparam logic [1:0] SEL_GO_SLEEP = 2'h2;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ          = 100;
   localparam int SLEEP_DELAY_US   = 35;   // Within 20..50 us
   localparam int SLEEP_DELAY_CYC  = SLEEP_DELAY_US * CLK_MHZ;
   localparam int WAKE_FILTER_NS   = 3000; // Longest filter, so phases are surely valid
   localparam int WAKE_FILTER_CYC  = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_TO_US       = 500;  // Shortest wake time-out
   localparam int WAKE_TO_CYC      = WAKE_TO_US * CLK_MHZ;
   localparam int TX_DTO_US        = 400;  // Shortest dominant time-out
   localparam int TX_DTO_CYC       = TX_DTO_US * CLK_MHZ;
   localparam int BUS_FAIL_CYCLES  = 4;
   localparam int CNT_W            = 20;

endpackage

// ---- verification/can_bus_model.sv ----
`timescale 1ns/1ns
// ---------------------------------------------
// Bus wire as sensed by the transceiver
// ---------------------------------------------
module can_bus_model (
   // Drivers on the wire
   input  wire logic bus_drive,
   input  wire logic remote_dom,
   // Sensed level
   output logic      bus_dominant
);
   // Any dominant driver wins over recessive bias
   assign bus_dominant = bus_drive | remote_dom;
endmodule

// ---- verification/can_xcvr_ctrl_assertions.sv ----
`timescale 1ns/1ns
module can_xcvr_ctrl_chk #(
   parameter int SLEEP_CYC = 20
) (
   // Clock and reset
   input wire logic           clk,
   input wire logic           rst_n,
   // Pins
   input wire logic           enable,
   input wire logic           standby_select_low,
   input wire logic           error_low,
   input wire logic           bus_drive,
   input wire logic           regulator_switch_out,
   input wire logic           regulator_switch_oe,
   input can_xcvr_pkg::mode_t mode
);
   int         gs;
   logic [2:0] up;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Cycles in go-to-sleep and since reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gs <= 0;
         up <= 3'h0;
      end else begin
         gs <= (mode == can_xcvr_pkg::MODE_GO_SLEEP) ? gs + 1 : 0;
         up <= (up == 3'h7) ? up : up + 3'h1;
      end
   end
   property p_mode_legal;
      mode <= can_xcvr_pkg::MODE_SLEEP;
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("mode out of range");
   property p_mode_normal;
      up == 3'h7 && $past({enable, standby_select_low}, 2) == can_xcvr_pkg::SEL_NORMAL
      && $past({enable, standby_select_low}, 3) == can_xcvr_pkg::SEL_NORMAL
      && $past({enable, standby_select_low}, 4) == can_xcvr_pkg::SEL_NORMAL
      |-> mode == can_xcvr_pkg::MODE_NORMAL;
   endproperty
   a_mode_normal: assert property (p_mode_normal) else $error("normal not selected");
   property p_mode_silent;
      up == 3'h7 && $past({enable, standby_select_low}, 2) == can_xcvr_pkg::SEL_SILENT
      && $past({enable, standby_select_low}, 3) == can_xcvr_pkg::SEL_SILENT
      && $past({enable, standby_select_low}, 4) == can_xcvr_pkg::SEL_SILENT
      |-> mode == can_xcvr_pkg::MODE_SILENT;
   endproperty
   a_mode_silent: assert property (p_mode_silent) else $error("silent not selected");
   property p_drive;
      bus_drive |-> $past(mode) == can_xcvr_pkg::MODE_NORMAL;
   endproperty
   a_drive: assert property (p_drive) else $error("bus driven outside normal");
   property p_reg;
      regulator_switch_out && regulator_switch_oe == ($past(mode) != can_xcvr_pkg::MODE_SLEEP);
   endproperty
   a_reg: assert property (p_reg) else $error("regulator switch wrong");
   property p_sleep_from;
      $rose(mode == can_xcvr_pkg::MODE_SLEEP) |-> $past(mode) == can_xcvr_pkg::MODE_GO_SLEEP;
   endproperty
   a_sleep_from: assert property (p_sleep_from) else $error("sleep not via go-to-sleep");
   property p_sleep_delay;
      $rose(mode == can_xcvr_pkg::MODE_SLEEP) |-> gs >= SLEEP_CYC - 1;
   endproperty
   a_sleep_delay: assert property (p_sleep_delay) else $error("sleep entered early");
   property p_no_sleep_wake;
      mode == can_xcvr_pkg::MODE_GO_SLEEP && $past(mode) == can_xcvr_pkg::MODE_GO_SLEEP
      && !error_low |=> mode != can_xcvr_pkg::MODE_SLEEP;
   endproperty
   a_no_sleep_wake: assert property (p_no_sleep_wake) else $error("sleep with wake set");
endmodule
bind can_xcvr_ctrl can_xcvr_ctrl_chk #(.SLEEP_CYC(SLEEP_CYC)) u_chk (
   .clk(clk), .rst_n(rst_n), .enable(enable), .standby_select_low(standby_select_low),
   .error_low(error_low), .bus_drive(bus_drive), .regulator_switch_out(regulator_switch_out),
   .regulator_switch_oe(regulator_switch_oe), .mode(mode));

// ---- verification/can_xcvr_ctrl_tb.sv ----
`timescale 1ns/1ns
module can_xcvr_ctrl_tb;
   localparam int SC = 20;
   logic clk = 1'b0;
   logic rst_n, tx_data, enable, standby_select_low, remote_dom, core_supply_uv, battery_uv;
   logic battery_power_up, local_wake, bus_short, tx_rx_short, bus_clamp, over_temp;
   logic rx_data, error_low, bus_dominant, bus_drive, regulator_switch_out, regulator_switch_oe;
   logic pwon, wk, ws, bf, lf;
   can_xcvr_pkg::mode_t mode, em;
   int bad_count = 0, checked = 0, seed = 24, n;
   // Clock
   always #5 clk = ~clk;
   can_xcvr_ctrl #(.SLEEP_CYC(SC), .WAKE_TO(2000), .TX_DTO(100)) u_dut (.clk(clk),
      .rst_n(rst_n), .tx_data(tx_data), .enable(enable), .standby_select_low(standby_select_low),
      .rx_data(rx_data), .error_low(error_low), .bus_dominant(bus_dominant),
      .bus_drive(bus_drive), .regulator_switch_out(regulator_switch_out),
      .regulator_switch_oe(regulator_switch_oe), .core_supply_uv(core_supply_uv),
      .battery_uv(battery_uv), .battery_power_up(battery_power_up), .local_wake(local_wake),
      .bus_short(bus_short), .tx_rx_short(tx_rx_short), .bus_clamp(bus_clamp),
      .over_temp(over_temp), .mode(mode));
   can_bus_model u_bus (.bus_drive(bus_drive), .remote_dom(remote_dom),
      .bus_dominant(bus_dominant));
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic chk(input string s, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic chk_mode(input can_xcvr_pkg::mode_t e);
      checked++;
      if (mode !== e) begin
         bad_count++;
         $display("mismatch mode expected %0d seen %0d", e, mode);
      end
   endtask
   // Expected error output from the flag model
   function automatic logic err_exp();
      case (em)
         can_xcvr_pkg::MODE_NORMAL: return !(ws | bf);
         can_xcvr_pkg::MODE_SILENT: return !(pwon | lf);
         default: return !wk;
      endcase
   endfunction
   task automatic outs();
      chk("error_low", err_exp(), error_low);
      chk("regulator_switch_oe", em != can_xcvr_pkg::MODE_SLEEP, regulator_switch_oe);
      chk("regulator_switch_out", 1'b1, regulator_switch_out);
   endtask
   // Select a mode by pins and update the flag model
   task automatic go(input logic [1:0] s, input can_xcvr_pkg::mode_t e);
      {enable, standby_select_low} = s;
      cyc(8);
      if (em == can_xcvr_pkg::MODE_NORMAL && e != em) ws = 1'b0;
      if (e == can_xcvr_pkg::MODE_NORMAL && e != em) {pwon, wk, bf, lf} = 4'h0;
      em = e;
      chk_mode(e);
      outs();
   endtask
   // Random transmit and remote bus traffic
   task automatic traffic(input int k);
      logic d;
      repeat (k) begin
         tx_data = 1'($random(seed));
         remote_dom = 1'($random(seed));
         cyc(7);
         d = em == can_xcvr_pkg::MODE_NORMAL && !tx_data;
         chk("bus_drive", d, bus_drive);
         d = (em == can_xcvr_pkg::MODE_STANDBY) ? !wk : !(d | remote_dom);
         chk("rx_data", d, rx_data);
      end
      tx_data = 1'b1;
      remote_dom = 1'b0;
   endtask
   task automatic summarize();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      tx_data = 1'b1;
      {enable, standby_select_low, remote_dom, core_supply_uv, battery_uv} = 5'h00;
      {battery_power_up, local_wake, bus_short, tx_rx_short, bus_clamp, over_temp} = 6'h00;
      {pwon, wk, ws, bf, lf} = 5'h00;
      em = can_xcvr_pkg::MODE_STANDBY;
      cyc(4);
      rst_n = 1'b1;
      cyc(1);
      chk_mode(em);
      outs();
      chk("rx_data", 1'b1, rx_data);
      battery_power_up = 1'b1;
      cyc(6);
      battery_power_up = 1'b0;
      pwon = 1'b1;
      go(can_xcvr_pkg::SEL_SILENT, can_xcvr_pkg::MODE_SILENT);
      battery_uv = 1'b1;
      cyc(6);
      outs();
      battery_uv = 1'b0;
      traffic(8);
      go(can_xcvr_pkg::SEL_NORMAL, can_xcvr_pkg::MODE_NORMAL);
      traffic(16);
      bus_short = 1'b1;
      repeat (5) begin
         tx_data = 1'b0;
         cyc(6);
         tx_data = 1'b1;
         cyc(6);
      end
      bus_short = 1'b0;
      bf = 1'b1;
      outs();
      go(can_xcvr_pkg::SEL_SILENT, can_xcvr_pkg::MODE_SILENT);
      go(can_xcvr_pkg::SEL_NORMAL, can_xcvr_pkg::MODE_NORMAL);
      tx_data = 1'b0;
      cyc(50);
      chk("bus_drive", 1'b1, bus_drive);
      cyc(80);
      chk("bus_drive", 1'b0, bus_drive);
      tx_data = 1'b1;
      lf = 1'b1;
      go(can_xcvr_pkg::SEL_SILENT, can_xcvr_pkg::MODE_SILENT);
      for (int i = 0; i < 4; i++) begin
         if (i > 0) {tx_rx_short, bus_clamp, over_temp} = 3'h1 << (i - 1);
         cyc(6);
         {tx_rx_short, bus_clamp, over_temp} = 3'h0;
         lf = 1'b1;
         cyc(6);
         outs();
         remote_dom = 1'b1;
         cyc(6);
         remote_dom = 1'b0;
         lf = 1'b0;
         cyc(6);
         outs();
      end
      go(can_xcvr_pkg::SEL_NORMAL, can_xcvr_pkg::MODE_NORMAL);
      {enable, standby_select_low} = can_xcvr_pkg::SEL_GO_SLEEP;
      n = 0;
      while (mode !== can_xcvr_pkg::MODE_SLEEP && n < 200) begin
         cyc(1);
         n++;
      end
      chk("sleep_delay", n >= SC && n <= SC + 6, 1'b1);
      em = can_xcvr_pkg::MODE_SLEEP;
      cyc(2);
      outs();
      go(can_xcvr_pkg::SEL_STANDBY, can_xcvr_pkg::MODE_STANDBY);
      local_wake = 1'b1;
      cyc(350);
      local_wake = 1'b0;
      {wk, ws} = 2'h3;
      cyc(6);
      outs();
      chk("rx_data", 1'b0, rx_data);
      go(can_xcvr_pkg::SEL_GO_SLEEP, can_xcvr_pkg::MODE_GO_SLEEP);
      cyc(3 * SC);
      chk_mode(can_xcvr_pkg::MODE_GO_SLEEP);
      go(can_xcvr_pkg::SEL_NORMAL, can_xcvr_pkg::MODE_NORMAL);
      go(can_xcvr_pkg::SEL_SILENT, can_xcvr_pkg::MODE_SILENT);
      go(can_xcvr_pkg::SEL_STANDBY, can_xcvr_pkg::MODE_STANDBY);
      traffic(8);
      remote_dom = 1'b1;
      cyc(350);
      remote_dom = 1'b0;
      cyc(2100);
      outs();
      for (int i = 0; i < 4; i++) begin
         remote_dom = !i[0];
         cyc(350);
      end
      wk = 1'b1;
      outs();
      chk("rx_data", 1'b0, rx_data);
      core_supply_uv = 1'b1;
      cyc(6);
      core_supply_uv = 1'b0;
      wk = 1'b0;
      cyc(6);
      outs();
      summarize();
   end
   // Watchdog
   initial begin
      #300000;
      bad_count++;
      summarize();
   end
endmodule
